/* hw/global_xlate_request_regs.v */
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "xlate_req_regs.vh"

module global_xlate_request_regs #(
  parameter XLATE_REGS_PRESENT = 1,
  parameter TWO_SEC_STATES     = 1,
  parameter ARCH_V2            = 1
) (
  // clock and reset
  input  wire        SYS_CLK_I,
  input  wire        RST_N_I,
  // avalon-mm slave
  input  wire [9:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  input  wire        AVS_SECURE_I,
  output reg  [31:0] AVS_READDATA_O,
  output reg         AVS_WAITREQUEST_O,
  // translation engine request
  output reg         XLATE_START_O,
  output reg  [63:0] XLATE_ADDR_O,
  output reg  [7:0]  XLATE_CTX_O,
  output reg         XLATE_STAGE2_O,
  output reg         XLATE_PRIV_O,
  output reg         XLATE_WRITE_O,
  output reg         XLATE_SECURE_O,
  output reg         XLATE_BUSY_O,
  // translation engine answer
  input  wire        XLATE_DONE_I,
  input  wire [63:0] XLATE_RESULT_I
);

  ////////////////////////////////////////////////////////////////////////
  // states

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         dest_sec_q;
  // result copies live in the generate block below, one per security state
  reg  [31:0] rdata_d;
  reg  [63:0] result_sel;
  reg         done_sel;

  wire [2:0]  req_lo;
  wire        req_hi;
  wire        res_lo;
  wire        res_hi;
  wire        status;
  wire        use_secure;
  wire        alias_hit;
  wire        busy;
  wire        is_req_write;
  wire        stall;
  wire        accept;
  wire        take_write;
  wire        req_go;
  wire        dest_sec;
  wire [63:0] req_value;
  wire [63:0] addr_mask;
  // sequencing and result copies
  wire        start_now;
  wire        done_take;
  wire [63:0] result_all [0:1];
  wire [1:0]  done_all;

  genvar      g;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // access kind of a request register as {stage2, priv, write}; the
  // select is one-hot, anything else gives the harmless all-zero kind,
  // which never reaches the engine because no start goes with it
  function [2:0] kind_of;
    input [2:0] sel;
    case (sel)
      3'b001:  kind_of = 3'b001;
      3'b010:  kind_of = 3'b110;
      3'b100:  kind_of = 3'b111;
      default: kind_of = 3'b000;
    endcase
  endfunction

  // the older layout has no upper result word, so that half reads zero
  function [63:0] fit_result;
    input [63:0] raw;
    fit_result = (ARCH_V2 != 0) ? raw : {32'h00000000, raw[31:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // address decode

  xlate_req_decode #(
    .TWO_SEC_STATES (TWO_SEC_STATES),
    .ARCH_V2        (ARCH_V2)
  ) u_decode (
    .addr_i       (AVS_ADDRESS_I),
    .secure_i     (AVS_SECURE_I),
    .req_lo_o     (req_lo),
    .req_hi_o     (req_hi),
    .res_lo_o     (res_lo),
    .res_hi_o     (res_hi),
    .status_o     (status),
    .use_secure_o (use_secure),
    .alias_o      (alias_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshake

  assign busy         = (state_q != ST_IDLE);
  assign is_req_write = AVS_WRITE_I && (req_lo != 3'h0);
  // a new request waits while one is in flight, so the result of the
  // first one is stored before a later request can start
  // limitation: a stalled write holds the bus, so status cannot be polled behind it
  assign stall        = is_req_write && busy;
  assign accept       = AVS_WAITREQUEST_O && (AVS_READ_I || AVS_WRITE_I) && !stall;
  // a write takes effect only at the edge the master sees waitrequest low
  assign take_write   = !AVS_WAITREQUEST_O && AVS_WRITE_I;

  // partial-lane writes are not atomic 32-bit writes and are dropped
  // upper-word writes never start anything and change no state
  assign req_go = take_write && (req_lo != 3'h0) && !req_hi &&
                  (AVS_BYTEENABLE_I == `BE_FULL) &&
                  (XLATE_REGS_PRESENT != 0);
  // reserved bits need no gate here: the address mask drops them below

  // one translation in flight: start only from idle, take a done only
  // while waiting and never in the start cycle itself
  assign start_now = (state_q == ST_IDLE) && req_go;
  assign done_take = (state_q == ST_WAIT) && XLATE_DONE_I && !XLATE_START_O;

  // secure copy only for a banked secure access; alias lands on non-secure
  assign dest_sec = use_secure && !alias_hit;

  ////////////////////////////////////////////////////////////////////////
  // request value: low word zero-extended, reserved bits cleared

  assign req_value = {32'h00000000, AVS_WRITEDATA_I};

  // only the address field survives into the input address
  assign addr_mask = {{32{1'b0}},
                      {(`POS_ADDR_MSB - `POS_ADDR_LSB + 1){1'b1}},
                      {`POS_ADDR_LSB{1'b0}}};

  always @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= `RST_READDATA;
    end else begin
      if (!AVS_WAITREQUEST_O) begin
        AVS_WAITREQUEST_O <= 1'b1;
      end else if (accept) begin
        // waitrequest drops for one cycle; read data is latched here so it
        // stands at the edge the master takes it, and holds until the next read
        AVS_WAITREQUEST_O <= 1'b0;
        if (AVS_READ_I) begin
          AVS_READDATA_O <= rdata_d;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux

  always @* begin
    // alias accesses leave dest_sec low, so they see the non-secure copy
    result_sel = dest_sec ? result_all[1] : result_all[0];
    done_sel   = dest_sec ? done_all[1] : done_all[0];
    rdata_d    = `RST_READDATA;
    if (AVS_READ_I) begin
      if (res_lo) begin
        rdata_d = result_sel[31:0];
      end else if (res_hi) begin
        rdata_d = result_sel[63:32];
      end else if (status) begin
        rdata_d[`POS_STAT_BUSY] = busy;
        rdata_d[`POS_STAT_DONE] = done_sel;
      end
      // request registers and unmapped words read as zero
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // translation sequencing

  // idle until a request is taken, then wait for the engine's single answer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req_go) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (done_take) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // engine request registers

  always @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state_q        <= ST_IDLE;
      dest_sec_q     <= 1'b0;
      XLATE_START_O  <= 1'b0;
      XLATE_ADDR_O   <= 64'h0000000000000000;
      XLATE_CTX_O    <= 8'h00;
      XLATE_STAGE2_O <= 1'b0;
      XLATE_PRIV_O   <= 1'b0;
      XLATE_WRITE_O  <= 1'b0;
      XLATE_SECURE_O <= 1'b0;
      XLATE_BUSY_O   <= 1'b0;
    end else begin
      state_q       <= state_d;
      // busy follows the next state: it rises with the start pulse and falls as the done is taken
      XLATE_BUSY_O  <= (state_d != ST_IDLE);
      XLATE_START_O <= 1'b0;
      if (start_now) begin
        XLATE_START_O  <= 1'b1;
        dest_sec_q     <= dest_sec;
        XLATE_SECURE_O <= dest_sec;
        XLATE_ADDR_O   <= req_value & addr_mask;
        XLATE_CTX_O    <= AVS_WRITEDATA_I[`POS_CTX_MSB:`POS_CTX_LSB];
        // kind is latched with the address so the engine sees one request
        {XLATE_STAGE2_O, XLATE_PRIV_O, XLATE_WRITE_O} <= kind_of(req_lo);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result registers: copy 0 non-secure, copy 1 secure

  generate
    for (g = 0; g < 2; g = g + 1) begin : copy
      reg  [63:0] result_q;
      reg         done_q;
      wire        start_hit;
      wire        done_hit;

      // a start aims at the copy of the access; the answer follows the
      // copy latched at start, since the bus may have moved on by then
      assign start_hit = start_now && (dest_sec == (g != 0));
      assign done_hit  = done_take && (dest_sec_q == (g != 0));

      always @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
          result_q <= `RST_RESULT;
          done_q   <= 1'b0;
        end else begin
          // a new request clears the done flag of the copy it targets
          if (start_hit) begin
            done_q <= 1'b0;
          end
          if (done_hit) begin
            result_q <= fit_result(XLATE_RESULT_I);
            done_q   <= 1'b1;
          end
        end
      end

      assign result_all[g] = result_q;
      assign done_all[g]   = done_q;
    end
  endgenerate

endmodule
`default_nettype wire

/* hw/xlate_req_regs.vh */
`ifndef XLATE_REQ_REGS_VH
`define XLATE_REQ_REGS_VH

////////////////////////////////////////////////////////////////////////
// register groups, selected by byte address bits [9:8]
`define GRP_BANKED        2'h0
`define GRP_ALIAS         2'h1

////////////////////////////////////////////////////////////////////////
// word offsets inside a group, byte address bits [7:2]
`define OFS_S1UW_LO       6'h00
`define OFS_S1UW_HI       6'h01
`define OFS_S12PR_LO      6'h02
`define OFS_S12PR_HI      6'h03
`define OFS_S12PW_LO      6'h04
`define OFS_S12PW_HI      6'h05
`define OFS_RESULT_LO     6'h06
`define OFS_RESULT_HI     6'h07
`define OFS_STATUS        6'h08

////////////////////////////////////////////////////////////////////////
// request word fields
`define POS_ADDR_MSB      31
`define POS_ADDR_LSB      12
`define POS_RSVD_MSB      11
`define POS_RSVD_LSB      8
`define POS_CTX_MSB       7
`define POS_CTX_LSB       0

////////////////////////////////////////////////////////////////////////
// status word fields
`define POS_STAT_BUSY     0
`define POS_STAT_DONE     1

////////////////////////////////////////////////////////////////////////
// reset values and bus constants
`define RST_RESULT        64'h0000000000000000
`define RST_READDATA      32'h00000000
`define BE_FULL           4'hf

`endif

/* hw/xlate_req_decode.v */
`timescale 1ns/100ps
`default_nettype none
`include "xlate_req_regs.vh"

module xlate_req_decode #(
  parameter TWO_SEC_STATES = 1,
  parameter ARCH_V2        = 1
) (
  // access
  input  wire [9:0] addr_i,
  input  wire       secure_i,
  // decoded targets
  output wire [2:0] req_lo_o,
  output wire       req_hi_o,
  output wire       res_lo_o,
  output wire       res_hi_o,
  output wire       status_o,
  output wire       use_secure_o,
  output wire       alias_o
);

  wire       banked;
  wire       alias_ok;
  wire       grp_ok;
  wire [5:0] word;

  assign banked   = (addr_i[9:8] == `GRP_BANKED);
  // the alias group exists only with two security states, and only secure software may use it
  assign alias_ok = (addr_i[9:8] == `GRP_ALIAS) && secure_i && (TWO_SEC_STATES != 0);
  assign grp_ok   = banked || alias_ok;
  assign word     = addr_i[7:2];

  // banked offsets hit the copy matching the access security state
  assign use_secure_o = banked && secure_i && (TWO_SEC_STATES != 0);
  assign alias_o      = alias_ok;

  assign req_lo_o[0] = grp_ok && (word == `OFS_S1UW_LO);
  assign req_lo_o[1] = grp_ok && (word == `OFS_S12PR_LO);
  assign req_lo_o[2] = grp_ok && (word == `OFS_S12PW_LO);
  // upper words exist only in the 64-bit layout
  assign req_hi_o    = grp_ok && (ARCH_V2 != 0) &&
                       ((word == `OFS_S1UW_HI) || (word == `OFS_S12PR_HI) || (word == `OFS_S12PW_HI));
  assign res_lo_o    = grp_ok && (word == `OFS_RESULT_LO);
  assign res_hi_o    = grp_ok && (ARCH_V2 != 0) && (word == `OFS_RESULT_HI);
  assign status_o    = grp_ok && (word == `OFS_STATUS);

endmodule
`default_nettype wire

/* bench/xreq_props.sv */
`timescale 1ns/100ps
`default_nettype none
module xreq_props (
  // clock, reset and bus
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic [9:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic        AVS_SECURE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // engine side
  input wire logic        XLATE_START_O,
  input wire logic [63:0] XLATE_ADDR_O,
  input wire logic [7:0]  XLATE_CTX_O,
  input wire logic        XLATE_STAGE2_O,
  input wire logic        XLATE_PRIV_O,
  input wire logic        XLATE_WRITE_O,
  input wire logic        XLATE_SECURE_O,
  input wire logic        XLATE_BUSY_O,
  input wire logic        XLATE_DONE_I
);
  ////////////////////////////////////////////////////////////////////////
  // a write is taken only at the edge that sees waitrequest low
  wire       tk = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire [5:0] wd = AVS_ADDRESS_I[7:2];
  wire       lo = (wd == 6'h00) || (wd == 6'h02) || (wd == 6'h04);
  wire       go = tk && lo && (AVS_BYTEENABLE_I == 4'hf);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low twice");
  start_pulse_a: assert property (XLATE_START_O |=> !XLATE_START_O && XLATE_BUSY_O)
    else $error("start not a pulse");
  req_fields_a: assert property (go && AVS_ADDRESS_I[9:8] == 2'h0 |=> XLATE_START_O
    && XLATE_ADDR_O == {32'h0, $past(AVS_WRITEDATA_I[31:12]), 12'h000}
    && XLATE_CTX_O == $past(AVS_WRITEDATA_I[7:0]) && XLATE_SECURE_O == $past(AVS_SECURE_I))
    else $error("request fields wrong");
  kind_code_a: assert property (go && AVS_ADDRESS_I[9:8] == 2'h0 |=>
    {XLATE_STAGE2_O, XLATE_PRIV_O, XLATE_WRITE_O} == ($past(wd) == 6'h00 ? 3'b001 :
    $past(wd) == 6'h02 ? 3'b110 : 3'b111))
    else $error("kind wrong");
  upper_drop_a: assert property (tk && !go |=> !XLATE_START_O)
    else $error("dropped write started");
  alias_ns_a: assert property (go && AVS_ADDRESS_I[9:8] == 2'h1 |=>
    XLATE_START_O == $past(AVS_SECURE_I) && !(XLATE_START_O && XLATE_SECURE_O))
    else $error("alias wrong");
  read_zero_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && wd < 6'h06 |->
    AVS_READDATA_O == 32'h00000000)
    else $error("request read not zero");
  done_busy_a: assert property (XLATE_BUSY_O && XLATE_DONE_I && !XLATE_START_O |=> !XLATE_BUSY_O)
    else $error("busy after done");
endmodule
bind global_xlate_request_regs xreq_props u_props (.*);
`default_nettype wire

/* bench/global_xlate_request_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module global_xlate_request_regs_test;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [9:0]  adr = 0;
  logic        rd = 0;
  logic        wr = 0;
  logic        sec = 0;
  logic        dn = 0;
  logic [31:0] wdat = 0;
  logic [31:0] q;
  logic [3:0]  be = 4'hf;
  logic [63:0] res = 0;
  wire  [31:0] rdat;
  wire  [63:0] xa;
  wire  [7:0]  xc;
  wire         wrq, st, s2, pv, xw, xs, bz;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  global_xlate_request_regs dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_SECURE_I(sec),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq), .XLATE_START_O(st), .XLATE_ADDR_O(xa),
    .XLATE_CTX_O(xc), .XLATE_STAGE2_O(s2), .XLATE_PRIV_O(pv), .XLATE_WRITE_O(xw),
    .XLATE_SECURE_O(xs), .XLATE_BUSY_O(bz), .XLATE_DONE_I(dn), .XLATE_RESULT_I(res));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("errors %0d checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hung waitrequest would otherwise stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      stop_test;
    end
  end
  task chk(input logic [79:0] g, input logic [79:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic s, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    sec <= s;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wrq !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task fin(input logic [63:0] r);
    @(posedge clk);
    res <= r;
    dn <= 1;
    @(posedge clk);
    dn <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_kinds;
    logic [2:0]  kd [3];
    logic [19:0] a20;
    kd = '{3'b001, 3'b110, 3'b111};
    for (int i = 0; i < 6; i++) begin
      a20 = 20'habc00 | i[2:1];
      bus(1, i[0], {5'h00, i[2:1], 3'h0}, {a20, 4'hf, 7'h20, i[0]});
      chk({st, bz, xs, xc}, {2'b11, i[0], 7'h20, i[0]});
      chk(xa, {32'h0, a20, 12'h000});
      chk({s2, pv, xw}, kd[i[2:1]]);
      fin({32'h0, a20, 11'h000, i[0]});
      bus(0, i[0], 10'h018, 32'h0);
      chk(q, {a20, 11'h000, i[0]});
      bus(0, i[0], 10'h020, 32'h0);
      chk(q, 32'h2);
      bus(0, i[0], {5'h00, i[2:1], 3'h0}, 32'h0);
      chk(q, 32'h0);
    end
    bus(0, 0, 10'h018, 32'h0);
    chk(q, 32'habc02000);
  endtask
  task t_drop;
    bus(1, 0, 10'h004, 32'hffff_f0ff);
    chk({st, xa}, {1'b0, 64'habc02000});
    bus(1, 0, 10'h100, 32'h0000_1000);
    chk(st, 0);
    @(posedge clk) be <= 4'h3;
    bus(1, 0, 10'h008, 32'h0000_2000);
    chk(st, 0);
    @(posedge clk) be <= 4'hf;
    bus(0, 0, 10'h3fc, 32'h0);
    chk(q, 32'h0);
    bus(1, 1, 10'h110, 32'h0000_3f07);
    chk({st, xs, xa, xc}, {2'b10, 64'h3000, 8'h07});
    fin(64'h1234_5678_0000_0000);
    bus(0, 0, 10'h01c, 32'h0);
    chk(q, 32'h1234_5678);
    bus(0, 1, 10'h11c, 32'h0);
    chk(q, 32'h1234_5678);
  endtask
  // a request while busy must wait for the done, not be lost
  task t_stall;
    bus(1, 1, 10'h000, 32'h0000_5001);
    fork
      bus(1, 1, 10'h010, 32'h0000_6002);
      begin
        repeat (4) @(posedge clk);
        #1 chk({st, wrq}, 2'b01);
        fin(64'h0);
      end
    join
    chk({st, xa, xc, s2, pv, xw}, {1'b1, 64'h6000, 8'h02, 3'b111});
    fin(64'h0);
  endtask
  // a reset in mid-translation drops the request and clears busy and the non-secure status
  task t_reset;
    bus(1, 0, 10'h008, 32'h0000_7001);
    @(posedge clk) rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    #1 chk({st, bz, xs, s2, pv, xw, xc, xa}, 0);
    bus(0, 0, 10'h020, 32'h0);
    chk(q, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    t_kinds;
    t_drop;
    t_stall;
    t_reset;
    stop_test;
  end
endmodule
`default_nettype wire
